// file: bench/sip_checker.sv
`timescale 1ns/1ps
`default_nettype none
// port checker for the prescaler
module sip_checker (
   // clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata_ff,
   // watchdog select and outputs
   input wire logic [2:0] wdog_clk_sel,
   input wire logic       interval_irq_line_ff,
   input wire logic       wdog_clk_ff,
   input wire logic       wdog_clear_ff
);
   logic ctl_wr;
   logic sel_wd;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // control writes and watchdog codes that pick us
   assign ctl_wr = reg_wr && reg_addr == 4'h0;
   assign sel_wd = wdog_clk_sel == 3'h4 || wdog_clk_sel == 3'h6;
   sequence s_init;
      ctl_wr && reg_wdata[0];
   endsequence
   sequence s_ctl_rd;
      reg_rd && reg_addr == 4'h0 ##1 1'b1;
   endsequence
   property p_quiet;
      $rose(rst_n) |-> !interval_irq_line_ff && !wdog_clear_ff;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("outputs busy after reset");
   property p_wd_clr;
      s_init ##0 sel_wd |-> ##[1:2] wdog_clear_ff;
   endproperty
   a_wd_clr: assert property (p_wd_clr)
      else $error("no watchdog clear");
   property p_wd_sel;
      $rose(wdog_clear_ff) |-> sel_wd;
   endproperty
   a_wd_sel: assert property (p_wd_sel)
      else $error("watchdog clear with other source");
   property p_wd_phase;
      s_init |-> ##2 !wdog_clk_ff [*4];
   endproperty
   a_wd_phase: assert property (p_wd_phase)
      else $error("watchdog clock not restarted");
   property p_rd_init;
      s_ctl_rd |-> reg_rdata_ff[5:4] == 2'h0 && !reg_rdata_ff[0];
   endproperty
   a_rd_init: assert property (p_rd_init)
      else $error("init bit reads nonzero");
   property p_irq_eq;
      s_ctl_rd |-> $past(interval_irq_line_ff) ==
                   (reg_rdata_ff[7] && reg_rdata_ff[6]);
   endproperty
   a_irq_eq: assert property (p_irq_eq)
      else $error("request differs from flag and enable");
   property p_irq_fall;
      $fell(interval_irq_line_ff) |-> $past(ctl_wr);
   endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("request dropped without write");
   property p_off;
      ctl_wr && !reg_wdata[6] |=> !interval_irq_line_ff;
   endproperty
   a_off: assert property (p_off)
      else $error("request while disabled");
endmodule // sip_checker
`default_nettype wire

// file: bench/sip_subclk.sv
`timescale 1ns/1ps
`default_nettype none
// subclock source, one tick every DIV cycles while running
module sip_subclk #(
   parameter int DIV = 2
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // oscillator control and ticks
   input  wire logic run,
   output logic      sub_tick,
   output logic      sub_osc_running
);
   int cnt_ff;
   // tick counter, held at zero while stopped
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 0;
         sub_tick <= 1'b0;
      end else begin
         cnt_ff <= (!run || cnt_ff == DIV - 1) ? 0 : cnt_ff + 1;
         sub_tick <= run && cnt_ff == DIV - 1;
      end
   end
   assign sub_osc_running = run;
endmodule // sip_subclk
`default_nettype wire

// file: bench/subclock_interval_prescaler_test.sv
`timescale 1ns/1ps
`default_nettype none
module subclock_interval_prescaler_test;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       run = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       in_main_mode = 1'b0;
   logic       stop_req = 1'b0;
   logic       osc_en = 1'b1;
   logic       rc_en = 1'b1;
   logic [2:0] wdog_clk_sel = 3'h0;
   logic [7:0] reg_rdata_ff;
   logic       sub_tick;
   logic       sub_osc_running;
   logic       interval_irq_line_ff;
   logic       wdog_clk_ff;
   logic       wdog_clear_ff;
   logic [7:0] rd_val;
   int         fails = 0;
   int         total_checks = 0;
   int         cyc = 0;
   int         t0;
   int         exp_c;
   int         hits;
   // rows: interval code, exponent; watchdog code, pulses
   logic [2:0] row_sel [3] = '{3'h4, 3'h0, 3'h1};
   int         row_exp [3] = '{10, 11, 12};
   logic [2:0] wd_sel [4] = '{3'h4, 3'h6, 3'h0, 3'h7};
   int         wd_hit [4] = '{1, 1, 0, 0};
   // clock and cycle count
   always #10 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   sip_subclk #(.DIV(2)) sip_subclk_inst (
      .clk, .rst_n, .run, .sub_tick, .sub_osc_running);
   sip_prescaler sip_prescaler_inst (
      .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata_ff, .sub_tick, .sub_osc_running,
      .in_sub_mode(!in_main_mode), .in_main_mode, .stop_req,
      .sub_osc_enable(osc_en), .sub_rc_osc_enable(rc_en), .wdog_clk_sel,
      .interval_irq_line_ff, .wdog_clk_ff, .wdog_clear_ff);
   task automatic check(input logic [7:0] seen, exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      rd_val = reg_rdata_ff;
      @(posedge clk);
   endtask
   task automatic wait_irq(input int lim);
      while (interval_irq_line_ff !== 1'b1) begin
         if (cyc > lim) begin
            fails++;
            complete_run();
         end
         @(posedge clk);
      end
   endtask
   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      run <= 1'b1;
      @(posedge clk);
      rd(4'h0);
      check(rd_val, 8'h00, "ctrl reset");
      rd(4'h1);
      check(rd_val, 8'h00, "count reset");
      for (int i = 0; i < 3; i++) begin
         exp_c = 1 << (row_exp[i] + 2);
         wr(4'h0, {4'h4, row_sel[i], 1'b1});
         t0 = cyc;
         for (int k = 1; k < 3; k++) begin
            wait_irq(t0 + k * exp_c + 16);
            check(8'(cyc - t0 > k * exp_c - 16), 8'h01, "interval");
            rd(4'h0);
            check(rd_val, {4'hC, row_sel[i], 1'b0}, "flag");
            wr(4'h0, {4'h4, row_sel[i], 1'b0});
            @(posedge clk);
            @(negedge clk);
            check(8'(interval_irq_line_ff), 8'h00, "irq clear");
            @(posedge clk);
         end
      end
      for (int i = 0; i < 4; i++) begin
         wdog_clk_sel <= wd_sel[i];
         wr(4'h0, 8'h09);
         hits = 0;
         repeat (4) begin
            @(negedge clk);
            hits += (wdog_clear_ff === 1'b1);
         end
         check(8'(hits), 8'(wd_hit[i]), "wdog clear");
         @(posedge clk);
      end
      wr(4'h0, 8'h09);
      repeat (4200) @(posedge clk);
      rd(4'h0);
      check(rd_val, 8'h88, "flag masked");
      check(8'(interval_irq_line_ff), 8'h00, "irq masked");
      wr(4'h0, 8'hC8);
      @(negedge clk);
      check(8'(interval_irq_line_ff), 8'h01, "irq on enable");
      @(posedge clk);
      wr(4'h0, 8'h08);
      in_main_mode <= 1'b1;
      osc_en <= 1'b0;
      repeat (4) @(posedge clk);
      osc_en <= 1'b1;
      rd(4'h2);
      check(rd_val, 8'hFF, "osc off clear");
      stop_req <= 1'b1;
      wr(4'h0, 8'h48);
      repeat (4200) @(posedge clk);
      rd(4'h0);
      check(rd_val, 8'h48, "main stop flag");
      rd(4'h2);
      check(rd_val, 8'hFB, "main stop count");
      rd(4'h3);
      check(rd_val, 8'h01, "main stop bit");
      rc_en <= 1'b0;
      repeat (4) @(posedge clk);
      rc_en <= 1'b1;
      rd(4'h2);
      check(rd_val, 8'hFF, "rc osc off clear");
      stop_req <= 1'b0;
      in_main_mode <= 1'b0;
      repeat (40) @(posedge clk);
      stop_req <= 1'b1;
      repeat (4) @(posedge clk);
      rd(4'h1);
      check(rd_val, 8'hFF, "sub stop clear");
      stop_req <= 1'b0;
      rd(4'hF);
      check(rd_val, 8'h00, "unmapped");
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (40) @(posedge clk);
      rd(4'h1);
      check(rd_val, 8'h00, "halt after reset");
      complete_run();
   end
endmodule // subclock_interval_prescaler_test
bind sip_prescaler sip_checker sip_checker_inst (
   .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff,
   .wdog_clk_sel, .interval_irq_line_ff, .wdog_clk_ff, .wdog_clear_ff);
`default_nettype wire

// file: verilog/sip_defines.vh
`ifndef SIP_DEFINES_VH
`define SIP_DEFINES_VH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SIP_ADDR_W          4
`define SIP_OFF_CTRL        4'h0
`define SIP_OFF_COUNT_LO    4'h1
`define SIP_OFF_COUNT_HI    4'h2
`define SIP_OFF_MODE        4'h3
// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define SIP_BIT_FLAG        7
`define SIP_BIT_IRQ_EN      6
`define SIP_BIT_SEL_HI      3
`define SIP_BIT_SEL_LO      1
`define SIP_BIT_INIT        0
`define SIP_CTRL_RESET      8'h00
// ----------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------
`define SIP_BIT_MAIN_STOP   0
`define SIP_MODE_RESET      8'h00
// ----------------------------------------------------------------
// counter values
// ----------------------------------------------------------------
`define SIP_CNT_W           16
`define SIP_CNT_ALL_ONES    16'hFFFF
`define SIP_CNT_ZERO        16'h0000
`define SIP_SEL_BASE_BIT    9
`define SIP_WDOG_SEL_A      3'h4
`define SIP_WDOG_SEL_B      3'h6
`define SIP_WDOG_TAP_BIT    12
`endif

// file: verilog/sip_div2.v
`timescale 1ns/1ps
`default_nettype none
// divides the subclock tick enable by two
module sip_div2 (
   // clock and reset
   input  wire clk,
   input  wire rst_n,
   // control
   input  wire clr,
   input  wire tick_in,
   // divided tick
   output reg  tick_out
);
   reg phase_ff;
   // ----------------------------------------------------------------
   // divider
   // ----------------------------------------------------------------
   // toggle on each input tick, pulse on every second one
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_ff <= 1'b0;
         tick_out <= 1'b0;
      end else if (clr) begin
         phase_ff <= 1'b0;
         tick_out <= 1'b0;
      end else begin
         tick_out <= tick_in & phase_ff;
         if (tick_in) begin
            phase_ff <= ~phase_ff;
         end
      end
   end
endmodule // sip_div2
`default_nettype wire

// file: verilog/sip_prescaler.v
// Overview of operation
// - counter decrements every count tick, subclock divided by two, while oscillator runs
// - software clear loads all ones and counting resumes from there
// - after zero the counter reloads all ones and keeps counting
// - flag sets at selected interval, except in main-clock stop mode
// - flag events repeat at the interval measured from the last clear
// - watchdog clear accompanies counter clear when watchdog selects codes 100 or 110
// - counter clears on entry to stop from subclock or sub-CR mode
// - counter clears when an oscillator enable drops in main clock modes
// - any reset loads the counter with zero and halts counting
// - watch mode entry behaves as sleep mode entry
// - main-clock stop mode keeps counting but raises no request
// - writing zero to the flag clears it and withdraws the request
// - writing one to the init bit reinitialises the counter
// - enable bit one forwards requests, zero blocks them
// - watchdog clock restarts from initial phase with the watchdog clear
// - request asserted while flag and enable are both one
// - enabling with flag already set raises the request at once
// - clear coinciding with selected bit overflow does not set the flag
// - select picks one of seven counter bits or the zero count, intervals 2^10 to 2^16
`timescale 1ns/1ps
`default_nettype none
`include "sip_defines.vh"
module sip_prescaler #(
   parameter CNT_W = `SIP_CNT_W
) (
   // clock and reset
   input  wire                   clk,
   input  wire                   rst_n,
   // register port
   input  wire [`SIP_ADDR_W-1:0] reg_addr,
   input  wire [7:0]             reg_wdata,
   input  wire                   reg_wr,
   input  wire                   reg_rd,
   output reg  [7:0]             reg_rdata_ff,
   // subclock source
   input  wire                   sub_tick,
   input  wire                   sub_osc_running,
   // system clock state
   input  wire                   in_sub_mode,
   input  wire                   in_main_mode,
   input  wire                   stop_req,
   input  wire                   sub_osc_enable,
   input  wire                   sub_rc_osc_enable,
   // watchdog clock selection
   input  wire [2:0]             wdog_clk_sel,
   // outputs
   output reg                    interval_irq_line_ff,
   output reg                    wdog_clk_ff,
   output reg                    wdog_clear_ff
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   reg  [CNT_W-1:0] count_ff;
   reg  [CNT_W-1:0] nxt_count;
   reg              flag_ff;
   reg              nxt_flag;
   reg              irq_en_ff;
   reg  [2:0]       sel_ff;
   reg              main_stop_ff;
   reg              run_ff;
   reg  [3:0]       bit_idx;
   wire             cnt_tick;
   wire             sosc_fall;
   wire             srco_fall;
   wire             stop_rise;
   wire             wr_ctrl;
   wire             init_wr;
   wire             mode_clr;
   wire             clr_any;
   wire             sel_ovf;
   wire [CNT_W-1:0] count_dec;

   assign wr_ctrl = reg_wr && (reg_addr == `SIP_OFF_CTRL);
   assign init_wr = wr_ctrl && reg_wdata[`SIP_BIT_INIT];

   // ----------------------------------------------------------------
   // count clock and mode events
   // ----------------------------------------------------------------
   // subclock halved
   sip_div2 u_div (
      .clk      (clk),
      .rst_n    (rst_n),
      .clr      (clr_any),
      .tick_in  (sub_tick & sub_osc_running & run_ff),
      .tick_out (cnt_tick)
   );

   // oscillator enable falling edges
   sip_sync_edge u_sosc (
      .clk      (clk),
      .rst_n    (rst_n),
      .level_in (sub_osc_enable),
      .fall     (sosc_fall),
      .rise     ()
   );

   sip_sync_edge u_srco (
      .clk      (clk),
      .rst_n    (rst_n),
      .level_in (sub_rc_osc_enable),
      .fall     (srco_fall),
      .rise     ()
   );

   // stop entry, watch and sleep entries cause no clear
   sip_sync_edge u_stop (
      .clk      (clk),
      .rst_n    (rst_n),
      .level_in (stop_req),
      .fall     (),
      .rise     (stop_rise)
   );

   assign mode_clr = (stop_rise && in_sub_mode) ||
                     ((sosc_fall || srco_fall) && in_main_mode);
   assign clr_any  = init_wr || mode_clr;

   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   // halted after reset until first clear
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_ff <= 1'b0;
      end else if (clr_any) begin
         run_ff <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   assign count_dec = count_ff - {{(CNT_W-1){1'b0}}, 1'b1};

   always @* begin
      nxt_count = count_ff;
      if (clr_any) begin
         nxt_count = `SIP_CNT_ALL_ONES;
      end else if (cnt_tick) begin
         if (count_ff == `SIP_CNT_ZERO) begin
            nxt_count = `SIP_CNT_ALL_ONES;
         end else begin
            nxt_count = count_dec;
         end
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_ff <= `SIP_CNT_ZERO;
      end else begin
         count_ff <= nxt_count;
      end
   end

   // ----------------------------------------------------------------
   // interval select
   // ----------------------------------------------------------------
   // code 100 is 2^10, 000..011 are 2^11..2^14, 101..111 above
   always @* begin
      bit_idx = 4'h0;
      case (sel_ff)
         3'h4:    bit_idx = 4'h9;
         3'h0:    bit_idx = 4'hA;
         3'h1:    bit_idx = 4'hB;
         3'h2:    bit_idx = 4'hC;
         3'h3:    bit_idx = 4'hD;
         3'h5:    bit_idx = 4'hE;
         3'h6:    bit_idx = 4'hF;
         default: bit_idx = 4'hF;
      endcase
   end

   // selected bit completes a down period
   assign sel_ovf = cnt_tick &&
                    (sel_ff == 3'h7 ? (count_ff == `SIP_CNT_ZERO)
                                     : (count_ff[bit_idx] == 1'b0 &&
                                        nxt_count[bit_idx] == 1'b1));

   // ----------------------------------------------------------------
   // control register and flag
   // ----------------------------------------------------------------
   // set unless main stop
   always @* begin
      nxt_flag = flag_ff;
      if (wr_ctrl && !reg_wdata[`SIP_BIT_FLAG]) begin
         nxt_flag = 1'b0;
      end
      if (sel_ovf && !clr_any && !(main_stop_ff && stop_req)) begin
         nxt_flag = 1'b1;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_ff      <= 1'b0;
         irq_en_ff    <= 1'b0;
         sel_ff       <= 3'h0;
         main_stop_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
         if (wr_ctrl) begin
            irq_en_ff <= reg_wdata[`SIP_BIT_IRQ_EN];
            sel_ff    <= reg_wdata[`SIP_BIT_SEL_HI:`SIP_BIT_SEL_LO];
         end
         if (reg_wr && (reg_addr == `SIP_OFF_MODE)) begin
            main_stop_ff <= reg_wdata[`SIP_BIT_MAIN_STOP];
         end else if (stop_req && in_main_mode) begin
            main_stop_ff <= 1'b1;
         end else if (!stop_req) begin
            main_stop_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupt and watchdog outputs
   // ----------------------------------------------------------------
   // flag and enable
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         interval_irq_line_ff <= 1'b0;
         wdog_clk_ff          <= 1'b0;
         wdog_clear_ff        <= 1'b0;
      end else begin
         interval_irq_line_ff <= nxt_flag && (wr_ctrl ?
                                 reg_wdata[`SIP_BIT_IRQ_EN] : irq_en_ff);
         wdog_clk_ff          <= ~nxt_count[`SIP_WDOG_TAP_BIT];
         wdog_clear_ff        <= clr_any &&
                                 ((wdog_clk_sel == `SIP_WDOG_SEL_A) ||
                                  (wdog_clk_sel == `SIP_WDOG_SEL_B));
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   // init bit and unused bits read zero
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == `SIP_OFF_CTRL) begin
            reg_rdata_ff <= {flag_ff, irq_en_ff, 2'b00, sel_ff, 1'b0};
         end else if (reg_addr == `SIP_OFF_COUNT_LO) begin
            reg_rdata_ff <= count_ff[7:0];
         end else if (reg_addr == `SIP_OFF_COUNT_HI) begin
            reg_rdata_ff <= count_ff[15:8];
         end else if (reg_addr == `SIP_OFF_MODE) begin
            reg_rdata_ff <= {7'h00, main_stop_ff};
         end else begin
            reg_rdata_ff <= 8'h00;
         end
      end else begin
         reg_rdata_ff <= 8'h00;
      end
   end
endmodule // sip_prescaler
`default_nettype wire

// file: verilog/sip_sync_edge.v
`timescale 1ns/1ps
`default_nettype none
// registers a level and flags its falling and rising edges
module sip_sync_edge (
   // clock and reset
   input  wire clk,
   input  wire rst_n,
   // level in
   input  wire level_in,
   // edges out
   output wire fall,
   output wire rise
);
   reg last_ff;
   // ----------------------------------------------------------------
   // edge detect
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_ff <= 1'b0;
      end else begin
         last_ff <= level_in;
      end
   end
   assign fall = last_ff & ~level_in;
   assign rise = ~last_ff & level_in;
endmodule // sip_sync_edge
`default_nettype wire
